// >>> core/deac_top.sv
// Eeprom access control block with an AXI4-Lite register slave.

// Operation
// RULE1 - Control register bits 7-4 read zero
// RULE2 - Software can only set read and start
// RULE3 - Hardware clears read and start on completion
// RULE4 - Read completes in one cycle
// RULE5 - Permit bit cleared at power-up
// RULE6 - Write starts only while permit set
// RULE7 - Abort flag set by aborting reset
// RULE8 - Abort flag one means last write aborted
// RULE9 - Aborting reset clears data and address
// RULE10 - Software checks abort, reloads, rewrites
// RULE11 - Done flag set when write completes
// RULE12 - Software clears done flag itself
// RULE13 - Unlock register reads all zeros
// RULE14 - Unlock access has no other effect
// RULE15 - Start bit zero means write finished
// RULE16 - Abort bit3, permit bit2, start bit1, read bit0
// RULE17 - Software leaves registers alone during write
// RULE18 - Start clear and done set together
module deac_top
  import deac_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = DEAC_WRITE_CYCLES,
  parameter int unsigned MEM_DEPTH    = 256
) (
  input  wire logic        CLOCK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        POWER_ON_RESET_I,
  input  wire logic        EXT_RESET_I,
  input  wire logic        WATCHDOG_RESET_I,
  input  wire logic        BROWNOUT_RESET_I,
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  output logic             WRITE_BUSY_O
);

  initial begin
    if (WRITE_CYCLES < 1 || WRITE_CYCLES > 65535) begin
      $error("WRITE_CYCLES out of range");
    end
    if (MEM_DEPTH < 1 || MEM_DEPTH > 256) begin
      $error("MEM_DEPTH out of range");
    end
  end

  function automatic logic known_ofs(input logic [7:0] a);
    return (a == DEAC_OFS_CONTROL) || (a == DEAC_OFS_UNLOCK) || (a == DEAC_OFS_DATA) ||
           (a == DEAC_OFS_ADDR) || (a == DEAC_OFS_FLAG);
  endfunction : known_ofs

  // ----------------------------------------------------------------------
  // Bus write channel
  // ----------------------------------------------------------------------
  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        wr_fire;
  logic        any_abort_reset;
  deac_ctrl_t  ctrl;
  logic        done_flag;
  logic [7:0]  data_reg;
  logic [7:0]  addr_reg;
  deac_state_t state;
  logic [15:0] wcount;
  logic [7:0]  mem [MEM_DEPTH];
  logic        write_finish;

  assign any_abort_reset = EXT_RESET_I | WATCHDOG_RESET_I | BROWNOUT_RESET_I;
  assign S_AXI_AWREADY_O = ~aw_held & ~S_AXI_BVALID_O;
  assign S_AXI_WREADY_O  = ~w_held & ~S_AXI_BVALID_O;
  assign wr_fire         = aw_held & w_held & ~S_AXI_BVALID_O;
  assign write_finish    = (state == DEAC_WRITE) && (wcount == 16'h0000);
  assign WRITE_BUSY_O    = ctrl.start;

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= DEAC_RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O  <= known_ofs(aw_addr) ? DEAC_RESP_OKAY : DEAC_RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  logic wr_lane0;
  assign wr_lane0 = wr_fire & w_strb[0];

  // ----------------------------------------------------------------------
  // Control register and write engine
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I || POWER_ON_RESET_I) begin
      ctrl   <= '0;  // see RULE5
      state  <= DEAC_IDLE;
      wcount <= 16'h0000;
    end else if (any_abort_reset) begin
      ctrl.abort  <= ctrl.start | ctrl.abort;  // see RULE7
      ctrl.permit <= 1'b0;
      ctrl.start  <= 1'b0;
      ctrl.read   <= 1'b0;
      state       <= DEAC_IDLE;
      wcount      <= 16'h0000;
    end else begin
      ctrl.read <= 1'b0;  // see RULE4
      if (wr_lane0 && aw_addr == DEAC_OFS_CONTROL) begin
        ctrl.abort  <= w_data[DEAC_BIT_ABORT];  // see RULE8
        ctrl.permit <= w_data[DEAC_BIT_PERMIT];
        if (w_data[DEAC_BIT_READ]) begin
          ctrl.read <= 1'b1;  // see RULE2
        end
      end
      case (state)
        DEAC_IDLE: begin
          if (wr_lane0 && aw_addr == DEAC_OFS_CONTROL && w_data[DEAC_BIT_START] &&
              w_data[DEAC_BIT_PERMIT]) begin
            ctrl.start <= 1'b1;  // see RULE6
            state      <= DEAC_WRITE;
            wcount     <= 16'(WRITE_CYCLES - 1);
          end
        end
        DEAC_WRITE: begin
          if (write_finish) begin
            ctrl.start <= 1'b0;  // see RULE3
            state      <= DEAC_IDLE;
          end else begin
            wcount <= wcount - 16'h0001;
          end
        end
        default: begin
          state <= DEAC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I || POWER_ON_RESET_I) begin
      done_flag <= 1'b0;
    end else if (write_finish && !any_abort_reset) begin
      done_flag <= 1'b1;  // see RULE11 see RULE18
    end else if (wr_lane0 && aw_addr == DEAC_OFS_FLAG) begin
      done_flag <= w_data[DEAC_BIT_DONE];
    end
  end

  // ----------------------------------------------------------------------
  // Data, address and storage
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I || POWER_ON_RESET_I || (any_abort_reset && ctrl.start)) begin
      data_reg <= DEAC_RST_DATA;  // see RULE9
      addr_reg <= DEAC_RST_ADDR;
    end else begin
      if (ctrl.read) begin
        data_reg <= mem[addr_reg];
      end else if (wr_lane0 && aw_addr == DEAC_OFS_DATA) begin
        data_reg <= w_data[7:0];
      end
      if (wr_lane0 && aw_addr == DEAC_OFS_ADDR) begin
        addr_reg <= w_data[7:0];
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (write_finish && !any_abort_reset && RESET_N_I && !POWER_ON_RESET_I) begin
      mem[addr_reg] <= data_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Bus read channel
  // ----------------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (S_AXI_ARADDR_I)
      DEAC_OFS_CONTROL: rd_word = {28'h0000000, ctrl};  // see RULE1 see RULE16 see RULE15
      DEAC_OFS_UNLOCK:  rd_word = 32'h0000_0000;        // see RULE13 see RULE14
      DEAC_OFS_DATA:    rd_word = {24'h000000, data_reg};
      DEAC_OFS_ADDR:    rd_word = {24'h000000, addr_reg};
      DEAC_OFS_FLAG:    rd_word = {24'h000000, done_flag, 7'h00};  // see RULE12
      default:          rd_word = 32'h0000_0000;
    endcase
  end

  assign S_AXI_ARREADY_O = ~S_AXI_RVALID_O;

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= 32'h0000_0000;
      S_AXI_RRESP_O  <= DEAC_RESP_OKAY;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O  <= rd_word;
      S_AXI_RRESP_O  <= known_ofs(S_AXI_ARADDR_I) ? DEAC_RESP_OKAY : DEAC_RESP_SLVERR;
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

endmodule : deac_top

// >>> core/deac_pkg.sv
// Package with register map, field positions and timing constants of the eeprom access control.
package deac_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] DEAC_OFS_CONTROL = 8'h00;
  localparam logic [7:0] DEAC_OFS_UNLOCK  = 8'h04;
  localparam logic [7:0] DEAC_OFS_DATA    = 8'h08;
  localparam logic [7:0] DEAC_OFS_ADDR    = 8'h0c;
  localparam logic [7:0] DEAC_OFS_FLAG    = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned DEAC_BIT_READ   = 0;
  localparam int unsigned DEAC_BIT_START  = 1;
  localparam int unsigned DEAC_BIT_PERMIT = 2;
  localparam int unsigned DEAC_BIT_ABORT  = 3;
  localparam int unsigned DEAC_BIT_DONE   = 7;

  // ----------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0]  DEAC_RST_DATA      = 8'h00;
  localparam logic [7:0]  DEAC_RST_ADDR      = 8'h00;
  localparam int unsigned DEAC_CLK_HZ        = 25000000;
  localparam int unsigned DEAC_WRITE_TIME_US = 5;
  localparam int unsigned DEAC_WRITE_CYCLES  = DEAC_WRITE_TIME_US * (DEAC_CLK_HZ / 1000000);
  localparam logic [1:0]  DEAC_RESP_OKAY     = 2'b00;
  localparam logic [1:0]  DEAC_RESP_SLVERR   = 2'b10;

  typedef enum logic [1:0] {
    DEAC_IDLE  = 2'b00,
    DEAC_WRITE = 2'b01
  } deac_state_t;

  typedef struct packed {
    logic abort;
    logic permit;
    logic start;
    logic read;
  } deac_ctrl_t;

endpackage : deac_pkg

// >>> sim/deac_top_sva.sv
// Assertion checker for the eeprom access control block.
module deac_top_sva
  import deac_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = 4
) (
  input wire logic        CLOCK_I,
  input wire logic        RESET_N_I,
  input wire logic        POWER_ON_RESET_I,
  input wire logic        EXT_RESET_I,
  input wire logic        WATCHDOG_RESET_I,
  input wire logic        BROWNOUT_RESET_I,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic        S_AXI_WVALID_I,
  input wire logic        S_AXI_WREADY_O,
  input wire logic        S_AXI_BVALID_O,
  input wire logic [7:0]  S_AXI_ARADDR_I,
  input wire logic        S_AXI_ARVALID_I,
  input wire logic        S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic        S_AXI_RVALID_O,
  input wire logic        WRITE_BUSY_O
);
  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  logic [15:0] busy_cnt;
  wire         abort_rst = EXT_RESET_I | WATCHDOG_RESET_I | BROWNOUT_RESET_I;
  wire         any_rst   = abort_rst | POWER_ON_RESET_I;
  wire         ar_unlock = S_AXI_ARVALID_I & S_AXI_ARREADY_O & (S_AXI_ARADDR_I == DEAC_OFS_UNLOCK);
  always_ff @(posedge CLOCK_I) begin
    busy_cnt <= (!RESET_N_I || !WRITE_BUSY_O) ? 16'h0000 : busy_cnt + 16'h0001;
  end
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);
  rdata_upper_a: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h000000)
    else $error("upper read bits set");
  busy_len_a: assert property ($fell(WRITE_BUSY_O) && $past(RESET_N_I && !any_rst) |->
    busy_cnt == WRITE_CYCLES) else $error("write length wrong");
  busy_max_a: assert property (WRITE_BUSY_O |-> busy_cnt < WRITE_CYCLES)
    else $error("write too long");
  busy_hold_a: assert property (WRITE_BUSY_O && !any_rst && busy_cnt + 1 < WRITE_CYCLES
    |=> WRITE_BUSY_O) else $error("write cut short");
  busy_cause_a: assert property ($rose(WRITE_BUSY_O) |-> $rose(S_AXI_BVALID_O) &&
    $past(S_AXI_WDATA_I[2:1]) == 2'b11) else $error("bad start");
  abort_drop_a: assert property (WRITE_BUSY_O && abort_rst |=> !WRITE_BUSY_O)
    else $error("abort kept write");
  por_clear_a: assert property (POWER_ON_RESET_I |=> !WRITE_BUSY_O)
    else $error("power-on kept write");
  unlock_zero_a: assert property (ar_unlock |=> S_AXI_RVALID_O && S_AXI_RDATA_O == 32'h0)
    else $error("unlock read not zero");
  write_done_c: cover property ($fell(WRITE_BUSY_O) && $past(!any_rst));
  abort_c: cover property (WRITE_BUSY_O && abort_rst);
  unlock_c: cover property (ar_unlock);
endmodule : deac_top_sva

bind deac_top deac_top_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_sva (.*);

// >>> sim/deac_top_tb.sv
// Self-checking testbench for the eeprom access control block.
module deac_top_tb import deac_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTL = DEAC_OFS_CONTROL;
  localparam logic [7:0] DAT = DEAC_OFS_DATA;
  localparam logic [7:0] ADR = DEAC_OFS_ADDR;
  logic        CLOCK_I = 1'b0, RESET_N_I = 1'b0, POWER_ON_RESET_I = 1'b0;
  logic        EXT_RESET_I = 1'b0, WATCHDOG_RESET_I = 1'b0, BROWNOUT_RESET_I = 1'b0;
  logic [7:0]  S_AXI_AWADDR_I = 8'h00, S_AXI_ARADDR_I = 8'h00;
  logic [31:0] S_AXI_WDATA_I = 32'h0, S_AXI_RDATA_O;
  logic [3:0]  S_AXI_WSTRB_I = 4'h1;
  logic        S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0, S_AXI_ARVALID_I = 1'b0;
  logic        S_AXI_BREADY_I = 1'b1, S_AXI_RREADY_I = 1'b1;
  logic        S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O;
  logic        S_AXI_RVALID_O, WRITE_BUSY_O;
  logic [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O;
  int          miscompares = 0, n_checks = 0, cycles = 0;
  always #20 CLOCK_I = ~CLOCK_I;
  deac_top #(.WRITE_CYCLES(8)) dut (.*);
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'b00);
    logic       ta, tw;
    logic [1:0] r;
    ta = 1'b0;
    tw = 1'b0;
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= d;
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WVALID_I <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge CLOCK_I);
      ta = ta | (S_AXI_AWVALID_I & S_AXI_AWREADY_O);
      tw = tw | (S_AXI_WVALID_I & S_AXI_WREADY_O);
      @(posedge CLOCK_I);
      if (ta) S_AXI_AWVALID_I <= 1'b0;
      if (tw) S_AXI_WVALID_I <= 1'b0;
    end
    do @(negedge CLOCK_I); while (S_AXI_BVALID_O !== 1'b1);
    r = S_AXI_BRESP_O;
    @(posedge CLOCK_I);
    chk({30'h0, r}, {30'h0, e});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e = 2'b00);
    logic [31:0] d;
    logic [1:0]  r;
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1'b1;
    do @(negedge CLOCK_I); while (S_AXI_ARREADY_O !== 1'b1);
    @(posedge CLOCK_I);
    S_AXI_ARVALID_I <= 1'b0;
    do @(negedge CLOCK_I); while (S_AXI_RVALID_O !== 1'b1);
    d = S_AXI_RDATA_O;
    r = S_AXI_RRESP_O;
    @(posedge CLOCK_I);
    chk(d, x);
    chk({30'h0, r}, {30'h0, e});
  endtask : rd
  always @(posedge CLOCK_I) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      $display("MISMATCH %0t timeout", $time);
      summarize();
    end
  end
  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge CLOCK_I);
    RESET_N_I <= 1'b1;
    @(posedge CLOCK_I);
    rd(CTL, 32'h00);
    rd(DEAC_OFS_UNLOCK, 32'h00);
    wr(DEAC_OFS_UNLOCK, 32'hff);
    wr(CTL, 32'h02);
    rd(CTL, 32'h00);
    rd(8'h20, 32'h00, DEAC_RESP_SLVERR);
    wr(8'h20, 32'h5a, DEAC_RESP_SLVERR);
    wr(CTL, 32'hf4);
    rd(CTL, 32'h04);
    wr(ADR, 32'h05);
    wr(DAT, 32'ha5);
    wr(CTL, 32'h06);
    wr(CTL, 32'h04);
    do @(negedge CLOCK_I); while (WRITE_BUSY_O !== 1'b0);
    @(posedge CLOCK_I);
    rd(CTL, 32'h04);
    rd(DEAC_OFS_FLAG, 32'h80);
    wr(DEAC_OFS_FLAG, 32'h00);
    rd(DEAC_OFS_FLAG, 32'h00);
    wr(DAT, 32'h00);
    wr(CTL, 32'h05);
    rd(DAT, 32'ha5);
    rd(CTL, 32'h04);
    for (int i = 0; i < 3; i++) begin
      wr(ADR, 32'h09);
      wr(DAT, 32'h3c);
      wr(CTL, 32'h06);
      {BROWNOUT_RESET_I, WATCHDOG_RESET_I, EXT_RESET_I} <= 3'b001 << i;
      @(posedge CLOCK_I);
      {BROWNOUT_RESET_I, WATCHDOG_RESET_I, EXT_RESET_I} <= 3'b000;
      rd(CTL, 32'h08);
      rd(DAT, 32'h00);
      rd(ADR, 32'h00);
      wr(CTL, 32'h00);
      rd(CTL, 32'h00);
    end
    wr(CTL, 32'h06);
    POWER_ON_RESET_I <= 1'b1;
    @(posedge CLOCK_I);
    POWER_ON_RESET_I <= 1'b0;
    rd(CTL, 32'h00);
    rd(DEAC_OFS_FLAG, 32'h00);
    summarize();
  end
endmodule : deac_top_tb
